// ===== rtl/spi_eeprom_front_end.sv
/*
 Serial command front end of a small SPI EEPROM: opcode capture and decode, status
 register, write-protect pin gating and the self-timed write cycle.
 Assumes the host drives selectN, sclk and serialIn in mode 0 or 3; sclk runs only
 inside frames. The system clock clk is unrelated to sclk.
*/
`timescale 1ns/10ps

module spi_eeprom_front_end
	import spi_eeprom_pkg::*;
#(
	parameter int WRITE_CYCLES = WRITE_CYCLES_DEFAULT
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic sclk,
	input wire logic selectN,
	input wire logic serialIn,
	input wire logic writeProtectN,
	output logic serialOut,
	output logic serialOutEn,
	output logic writeInProgress,
	output logic writeLatch,
	output logic protectPinEnable,
	output logic [1:0] blockProtect
);

	// ---------------- Link side (sclk) ----------------
	logic frameRstN;
	logic [5:0] bitCnt;
	logic [7:0] shiftIn;
	logic [7:0] opcode;
	logic opSeen;
	logic ignoreFrame;
	logic readMode;
	logic [7:0] nextByte;
	logic acceptOp;
	logic inFrame;
	logic busyLink;
	logic [7:0] statusMeta;
	logic [7:0] statusLink;
	logic doneTog;
	action_type action;
	logic [7:0] wrData;
	logic [2:0] outCnt;
	logic [7:0] outShift;
	logic [7:0] srcByte;

	// Select high holds all frame state in reset, so every frame starts clean
	assign frameRstN = nrst & ~selectN;
	assign nextByte = {shiftIn[6:0], serialIn};
	assign inFrame = opSeen & ~ignoreFrame;
	assign busyLink = statusLink[ST_BUSY];

	function automatic logic isSupported(input logic [7:0] op);
		case (op)
			OP_SET_LATCH, OP_CLR_LATCH, OP_STATUS_READ, OP_STATUS_WRITE, OP_MEM_READ, OP_MEM_WRITE: isSupported = 1'b1;
			default: isSupported = 1'b0;
		endcase
	endfunction

	// Busy device takes nothing but a status read
	assign acceptOp = isSupported(nextByte) & ~(busyLink & (nextByte != OP_STATUS_READ));

	always_ff @(posedge sclk or negedge frameRstN) begin
		if (!frameRstN) begin
			bitCnt <= 6'h00;
			shiftIn <= 8'h00;
		end else begin
			shiftIn <= nextByte;
			if (bitCnt != BIT_COUNT_MAX) begin
				bitCnt <= bitCnt + 6'h01;
			end
		end
	end

	always_ff @(posedge sclk or negedge frameRstN) begin
		if (!frameRstN) begin
			opcode <= 8'h00;
			opSeen <= 1'b0;
			ignoreFrame <= 1'b0;
			readMode <= 1'b0;
		end else begin
			if (bitCnt == OPCODE_LAST_BIT) begin
				opcode <= nextByte;
				opSeen <= 1'b1;
				ignoreFrame <= ~acceptOp;
				readMode <= acceptOp & (nextByte == OP_STATUS_READ);
			end
			if (inFrame && opcode == OP_MEM_READ && bitCnt == MEM_ADDR_LAST_BIT) begin
				readMode <= 1'b1;
			end
		end
	end

	// Kept across frames: the toggle and its payload must survive select rising
	always_ff @(posedge sclk or negedge nrst) begin
		if (!nrst) begin
			doneTog <= 1'b0;
			action <= ACT_NONE;
			wrData <= 8'h00;
		end else if (bitCnt == OPCODE_LAST_BIT && acceptOp && nextByte == OP_SET_LATCH) begin
			action <= ACT_SET_LATCH;
			doneTog <= ~doneTog;
		end else if (bitCnt == OPCODE_LAST_BIT && acceptOp && nextByte == OP_CLR_LATCH) begin
			action <= ACT_CLR_LATCH;
			doneTog <= ~doneTog;
		end else if (inFrame && opcode == OP_STATUS_WRITE && bitCnt == STATUS_DATA_LAST_BIT) begin
			action <= ACT_STATUS_WRITE;
			wrData <= nextByte;
			doneTog <= ~doneTog;
		end else if (inFrame && opcode == OP_MEM_WRITE && bitCnt == MEM_DATA_LAST_BIT) begin
			action <= ACT_MEM_WRITE;
			doneTog <= ~doneTog;
		end
	end

	// Status is quasi-static; two sclk edges settle it before the opcode ends
	always_ff @(posedge sclk or negedge nrst) begin
		if (!nrst) begin
			statusMeta <= 8'h00;
			statusLink <= 8'h00;
		end else begin
			statusMeta <= {protectPinEnable, 3'h0, blockProtect, writeLatch, writeInProgress};
			statusLink <= statusMeta;
		end
	end

	assign srcByte = (opcode == OP_STATUS_READ) ? statusLink : ERASED_BYTE;

	// Output released whenever deselected or the frame is not a read
	always_ff @(negedge sclk or negedge frameRstN) begin
		if (!frameRstN) begin
			outCnt <= 3'h0;
			outShift <= 8'h00;
			serialOut <= 1'b0;
			serialOutEn <= 1'b0;
		end else if (readMode) begin
			serialOutEn <= 1'b1;
			outCnt <= outCnt + 3'h1;
			if (outCnt == 3'h0) begin
				serialOut <= srcByte[7];
				outShift <= {srcByte[6:0], 1'b0};
			end else begin
				serialOut <= outShift[7];
				outShift <= {outShift[6:0], 1'b0};
			end
		end
	end

	// ---------------- System side (clk) ----------------
	logic selMeta;
	logic selSync;
	logic selPrev;
	logic wpMeta;
	logic wpSync;
	logic wpPrev;
	logic togMeta;
	logic togSync;
	logic togPrev;
	logic selRise;
	logic selFall;
	logic wpFall;
	logic togEvt;
	logic hwProtect;
	logic execOk;
	logic startWrite;
	action_type pendAct;
	logic [7:0] pendData;
	engine_type engine;
	logic [31:0] wcCnt;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			selMeta <= 1'b1;
			selSync <= 1'b1;
			selPrev <= 1'b1;
			wpMeta <= 1'b1;
			wpSync <= 1'b1;
			wpPrev <= 1'b1;
			togMeta <= 1'b0;
			togSync <= 1'b0;
			togPrev <= 1'b0;
		end else begin
			selMeta <= selectN;
			selSync <= selMeta;
			selPrev <= selSync;
			wpMeta <= writeProtectN;
			wpSync <= wpMeta;
			wpPrev <= wpSync;
			togMeta <= doneTog;
			togSync <= togMeta;
			togPrev <= togSync;
		end
	end

	assign selRise = selSync & ~selPrev;
	assign selFall = ~selSync & selPrev;
	assign wpFall = ~wpSync & wpPrev;
	assign togEvt = togSync ^ togPrev;
	// Pin only counts when its enable is set; pin high never blocks
	assign hwProtect = protectPinEnable & ~wpSync;
	assign execOk = selRise & ~writeInProgress;
	assign startWrite = execOk & writeLatch
		& ((pendAct == ACT_MEM_WRITE) | ((pendAct == ACT_STATUS_WRITE) & ~hwProtect));

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pendAct <= ACT_NONE;
			pendData <= 8'h00;
		end else if (selRise || selFall) begin
			pendAct <= ACT_NONE;
		end else if (togEvt) begin
			pendAct <= action;
			pendData <= wrData;
		end else if (wpFall && !selSync && pendAct == ACT_STATUS_WRITE && protectPinEnable) begin
			pendAct <= ACT_NONE;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			writeLatch <= LATCH_RESET;
		end else if (execOk && pendAct == ACT_SET_LATCH) begin
			writeLatch <= 1'b1;
		end else if (execOk && pendAct == ACT_CLR_LATCH) begin
			writeLatch <= 1'b0;
		end
	end

	// Fields load at the start, so a later pin fall cannot touch them
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			protectPinEnable <= PPE_RESET;
			blockProtect <= BP_RESET;
		end else if (startWrite && pendAct == ACT_STATUS_WRITE) begin
			protectPinEnable <= pendData[ST_PPE];
			blockProtect <= pendData[ST_BP_HI:ST_BP_LO];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			engine <= ENG_IDLE;
			wcCnt <= 32'h0;
			writeInProgress <= 1'b0;
		end else begin
			case (engine)
				ENG_IDLE: begin
					if (startWrite) begin
						engine <= ENG_BUSY;
						wcCnt <= 32'h0;
						writeInProgress <= 1'b1;
					end
				end
				ENG_BUSY: begin
					// Runs regardless of select, so deselecting never cuts it short
					if (wcCnt == 32'(WRITE_CYCLES - 1)) begin
						engine <= ENG_IDLE;
						writeInProgress <= 1'b0;
					end else begin
						wcCnt <= wcCnt + 32'h1;
					end
				end
				default: begin
					engine <= ENG_IDLE;
					writeInProgress <= 1'b0;
				end
			endcase
		end
	end

	// ---------------- Checks ----------------
	sequence seqCommit;
		selRise && !writeInProgress;
	endsequence

	sequence seqStatusArmed;
		pendAct == ACT_STATUS_WRITE && !selSync && protectPinEnable;
	endsequence

	chk_write_duration: assert property (@(posedge clk) disable iff (!nrst)
		(engine == ENG_BUSY && wcCnt == 32'(WRITE_CYCLES - 1)) |=> !writeInProgress)
		else $error("write cycle length wrong");
	chk_start_on_rise: assert property (@(posedge clk) disable iff (!nrst)
		$rose(writeInProgress) |-> $past(selRise)
		&& ($past(pendAct) == ACT_MEM_WRITE || $past(pendAct) == ACT_STATUS_WRITE))
		else $error("write started without select rise");

	chk_latch_set_cmd: assert property (@(posedge clk) disable iff (!nrst)
		$rose(writeLatch) |-> $past(pendAct) == ACT_SET_LATCH && $past(selRise))
		else $error("latch set without its command");
	chk_latch_clear_cmd: assert property (@(posedge clk) disable iff (!nrst)
		$fell(writeLatch) |-> $past(pendAct) == ACT_CLR_LATCH && $past(selRise))
		else $error("latch cleared without its command");

	chk_wp_inhibit: assert property (@(posedge clk) disable iff (!nrst)
		(seqCommit ##0 (pendAct == ACT_STATUS_WRITE && protectPinEnable && !wpSync)) |=> !writeInProgress)
		else $error("status write passed protect pin");

	chk_wp_abort: assert property (@(posedge clk) disable iff (!nrst)
		(seqStatusArmed ##0 wpFall) |=> pendAct == ACT_NONE)
		else $error("status write not aborted");

	chk_busy_ignores: assert property (@(posedge clk) disable iff (!nrst)
		(writeInProgress && selRise) |=> $stable(writeLatch) && $stable(protectPinEnable) && $stable(blockProtect))
		else $error("command taken during write cycle");

	chk_out_standby: assert property (@(posedge clk) disable iff (!nrst)
		selectN |-> !serialOutEn)
		else $error("output driven while deselected");

	chk_unknown_quiet: assert property (@(posedge sclk) disable iff (!frameRstN)
		ignoreFrame |-> !readMode && !serialOutEn)
		else $error("ignored frame still reads");

endmodule

// ===== common/spi_eeprom_pkg.sv
/*
 Constants shared by the serial EEPROM command front end: opcodes, frame bit counts,
 status register layout, reset values and internal write timing.
 Assumes a 200 MHz system clock.
*/
package spi_eeprom_pkg;

	// Supported operation codes
	localparam logic [7:0] OP_SET_LATCH = 8'h06;
	localparam logic [7:0] OP_CLR_LATCH = 8'h04;
	localparam logic [7:0] OP_STATUS_READ = 8'h05;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_MEM_READ = 8'h03;
	localparam logic [7:0] OP_MEM_WRITE = 8'h02;

	// Bit count (zero based) of the last bit of each frame section, and the count at which bitCnt stops
	localparam logic [5:0] OPCODE_LAST_BIT = 6'h07;
	localparam logic [5:0] STATUS_DATA_LAST_BIT = 6'h0f;
	localparam logic [5:0] MEM_ADDR_LAST_BIT = 6'h17;
	localparam logic [5:0] MEM_DATA_LAST_BIT = 6'h1f;
	localparam logic [5:0] BIT_COUNT_MAX = 6'h3f;

	// Status register fields
	localparam int ST_BUSY = 0;
	localparam int ST_LATCH = 1;
	localparam int ST_BP_LO = 2;
	localparam int ST_BP_HI = 3;
	localparam int ST_PPE = 7;

	// Values after reset
	localparam logic LATCH_RESET = 1'b0;
	localparam logic PPE_RESET = 1'b0;
	localparam logic [1:0] BP_RESET = 2'h0;

	// No array behind this front end; data reads return the erased value
	localparam logic [7:0] ERASED_BYTE = 8'hff;

	// Self-timed write cycle
	// Kept in ns so the write time stays inside a 32-bit int
	localparam int CLK_PERIOD_NS = 5;
	localparam int WRITE_TIME_NS = 10000000;
	localparam int WRITE_CYCLES_DEFAULT = WRITE_TIME_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {ACT_NONE, ACT_SET_LATCH, ACT_CLR_LATCH, ACT_STATUS_WRITE, ACT_MEM_WRITE} action_type;
	typedef enum logic {ENG_IDLE, ENG_BUSY} engine_type;

endpackage

// ===== verif/spi_host_model.sv
/*
 Host side of the serial link: mode 0, MSB first, sclk 80 ns, idle low between frames.
 Assumes the bench calls shift and release_select in turn, one command to a frame.
*/
`timescale 1ns/10ps
module spi_host_model (
	output logic sclk,
	output logic selectN,
	output logic serialIn,
	input wire logic serialOut,
	input wire logic serialOutEn
);
	logic enSeen;
	initial begin
		sclk = 1'b0;
		selectN = 1'b1;
		serialIn = 1'b0;
	end
	// Select stays low so the bench can act before the frame ends
	task automatic shift(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
		// Off the clk edges, so the synchronisers never race the pin
		#1;
		rx = '0;
		enSeen = 1'b0;
		selectN = 1'b0;
		#40;
		for (int i = nbits - 1; i >= 0; i--) begin
			serialIn = tx[i];
			#40;
			sclk = 1'b1;
			// Released line shows the inverse, so undriven bits never pass
			rx = {rx[30:0], serialOutEn ? serialOut : ~serialOut};
			enSeen = enSeen | serialOutEn;
			#40;
			sclk = 1'b0;
		end
		// No stale data left on the line
		serialIn = ~serialIn;
	endtask
	task automatic release_select();
		#21;
		selectN = 1'b1;
		#40;
	endtask
endmodule

// ===== verif/testbench.sv
/*
 Self-checking bench for the EEPROM command front end.
 Assumes the host model drives the link and the bench drives clk, nrst and the protect pin.
*/
`timescale 1ns/10ps
module testbench;
	import spi_eeprom_pkg::*;
	localparam int WCYC = 1000;
	logic clk = 1'b0;
	logic nrst, writeProtectN, sclk, selectN, serialIn, serialOut, serialOutEn;
	logic writeInProgress, writeLatch, protectPinEnable;
	logic [1:0] blockProtect;
	logic [31:0] rx;
	int miscompares = 0;
	int samplesChecked = 0;
	always #2.5 clk = ~clk;
	spi_eeprom_front_end #(.WRITE_CYCLES(WCYC)) spi_eeprom_front_end_inst (.clk(clk), .nrst(nrst), .sclk(sclk),
		.selectN(selectN), .serialIn(serialIn), .writeProtectN(writeProtectN), .serialOut(serialOut),
		.serialOutEn(serialOutEn), .writeInProgress(writeInProgress), .writeLatch(writeLatch),
		.protectPinEnable(protectPinEnable), .blockProtect(blockProtect));
	spi_host_model spi_host_model_inst (.sclk(sclk), .selectN(selectN), .serialIn(serialIn),
		.serialOut(serialOut), .serialOutEn(serialOutEn));
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [7:0] stat();
		return {protectPinEnable, 3'b000, blockProtect, writeLatch, writeInProgress};
	endfunction
	// Effects land in the clk domain a few cycles after select rises
	task automatic cmd(input logic [31:0] tx, input int n);
		spi_host_model_inst.shift(tx, n, rx);
		spi_host_model_inst.release_select();
		repeat (10) @(posedge clk);
	endtask
	task automatic read_status(input logic [7:0] exp);
		cmd({16'h0, OP_STATUS_READ, 8'h00}, 16);
		check(rx[7:0], exp);
		check(spi_host_model_inst.enSeen, 1'b1);
		check(serialOutEn, 1'b0);
	endtask
	task automatic wait_idle();
		for (int i = 0; i < WCYC + 100 && writeInProgress !== 1'b0; i++) @(posedge clk);
		check(writeInProgress, 1'b0);
	endtask
	task automatic pin(input logic v);
		@(posedge clk);
		writeProtectN <= v;
		repeat (4) @(posedge clk);
	endtask
	task automatic test_reset_and_latch();
		check(stat(), 8'h00);
		read_status(8'h00);
		cmd({24'h0, OP_SET_LATCH}, 8);
		read_status(8'h02);
		cmd({24'h0, OP_CLR_LATCH}, 8);
		check(writeLatch, 1'b0);
	endtask
	task automatic test_status_write();
		cmd({24'h0, OP_SET_LATCH}, 8);
		cmd({16'h0, OP_STATUS_WRITE, 8'h84}, 16);
		check(stat(), 8'h87);
		cmd({24'h0, OP_CLR_LATCH}, 8);
		check(writeLatch, 1'b1);
		read_status(8'h87);
		wait_idle();
		check(stat(), 8'h86);
	endtask
	task automatic test_protect();
		pin(1'b0);
		cmd({16'h0, OP_STATUS_WRITE, 8'h00}, 16);
		check(stat(), 8'h86);
		pin(1'b1);
		cmd({16'h0, OP_STATUS_WRITE, 8'h00}, 16);
		check(stat(), 8'h03);
		wait_idle();
		pin(1'b0);
		cmd({16'h0, OP_STATUS_WRITE, 8'h8c}, 16);
		check(stat(), 8'h8f);
		wait_idle();
		pin(1'b1);
		spi_host_model_inst.shift({16'h0, OP_STATUS_WRITE, 8'h00}, 16, rx);
		pin(1'b0);
		spi_host_model_inst.release_select();
		repeat (10) @(posedge clk);
		check(stat(), 8'h8e);
		pin(1'b1);
		cmd({16'h0, OP_STATUS_WRITE, 8'h80}, 16);
		pin(1'b0);
		check(stat(), 8'h83);
		wait_idle();
		check(stat(), 8'h82);
		pin(1'b1);
	endtask
	task automatic test_memory_and_unknown();
		cmd({OP_MEM_READ, 16'h0123, 8'h00}, 32);
		check(rx[7:0], ERASED_BYTE);
		check(spi_host_model_inst.enSeen, 1'b1);
		spi_host_model_inst.shift({OP_MEM_WRITE, 16'h0010, 8'h5a}, 32, rx);
		repeat (10) @(posedge clk);
		check(writeInProgress, 1'b0);
		spi_host_model_inst.release_select();
		repeat (10) @(posedge clk);
		check(writeInProgress, 1'b1);
		wait_idle();
		cmd({8'ha5, 8'h05, 16'h0}, 32);
		check(spi_host_model_inst.enSeen, 1'b0);
		check(stat(), 8'h82);
		cmd({24'h0, OP_CLR_LATCH}, 8);
		cmd({OP_MEM_WRITE, 16'h0010, 8'h5a}, 32);
		check(writeInProgress, 1'b0);
	endtask
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", samplesChecked, miscompares);
		if (miscompares == 0 && samplesChecked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#400us;
		miscompares++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		end_of_test();
	end
	initial begin
		nrst = 1'b0;
		writeProtectN = 1'b1;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		repeat (5) @(posedge clk);
		test_reset_and_latch();
		test_status_write();
		test_protect();
		test_memory_and_unknown();
		end_of_test();
	end
endmodule
